// [hw/phy_ctrl_pkg.sv]
// Constants for the PHY basic control register block.
// Assumes a 25 MHz clock and a simple synchronous management register port.
package phy_ctrl_pkg;
  localparam int          CLK_HZ            = 25_000_000;
  localparam logic [4:0]  PHY_BASIC_CONTROL = 5'h00;
  localparam logic [15:0] CTRL_RESET_VAL    = 16'h3100;
  localparam int          BIT_SOFT_RESET    = 15;
  localparam int          BIT_LOOPBACK      = 14;
  localparam int          BIT_SPEED         = 13;
  localparam int          BIT_AN_ENABLE     = 12;
  localparam int          BIT_POWER_DOWN    = 11;
  localparam int          BIT_ISOLATE       = 10;
  localparam int          BIT_AN_RESTART    = 9;
  localparam int          BIT_DUPLEX        = 8;
  localparam int          BIT_COL_TEST      = 7;
  localparam int          RESET_HOLD_CYC    = 16;
  localparam int          DEAD_TIME_MS      = 720;
  localparam int          DEAD_TIME_CYC     = DEAD_TIME_MS * (CLK_HZ / 1000);
endpackage

// [hw/phy_ctrl_if.sv]
// Carrier between the control register and its timer helper.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface phy_ctrl_if;
  logic start;
  logic busy;
  modport owner (output start, input busy);
  modport timer (input start, output busy);
endinterface

// [hw/phy_hold_timer.sv]
// Retriggerable down-counter: busy for COUNT cycles after start.
// Assumes start is a one-cycle pulse on clk.
`timescale 1ns/1ps
module phy_hold_timer #(
  parameter int COUNT = 16
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Control
  phy_ctrl_if.timer t
);
  localparam int W = $clog2(COUNT + 1);
  logic [W-1:0] cnt_r;

  // A zero count would leave busy stuck low and the hold meaningless
  if (COUNT < 1)
  begin
    $error("COUNT must be at least 1");
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cnt_r <= '0;
    else if (t.start)
      cnt_r <= W'(COUNT);
    else if (cnt_r != '0)
      cnt_r <= cnt_r - 1'b1;
  end

  assign t.busy = (cnt_r != '0);
endmodule

// [hw/phy_basic_mode_control.sv]
// Basic mode control register of the 10/100 PHY, with its side effects.
// Assumes a synchronous register port: one-cycle wr_en/rd_en, data valid next cycle.
// Operation
// - Writing bit 15 resets all PHY registers; reads one until reset completes.
// - Bit 14 enables loop-back; reset zero, read/write.
// - At 100 Mbps, loop-back can cause about 720 ms receive dead time.
// - Bit 13 selects 100 Mbps when one, 10 Mbps when zero; reset one.
// - With auto-negotiation on, speed bit reads the negotiated speed.
// - Bit 12 enables auto-negotiation, reset one; bits 8,13 show its result.
// - Bit 8 full duplex, reset one; writable only with auto-negotiation off.
// - Collision test asserts collision throughout each transmit period.
// - Bits 6 to 0 read zero and ignore writes.
`timescale 1ns/1ps
module phy_basic_mode_control
  import phy_ctrl_pkg::*;
#(
  parameter int RESET_HOLD = phy_ctrl_pkg::RESET_HOLD_CYC,
  parameter int DEAD_TIME  = phy_ctrl_pkg::DEAD_TIME_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Management register port
  input  wire logic [4:0]  reg_addr,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  input  wire logic        rd_en,
  output logic      [15:0] rd_data,
  output logic             rd_valid,
  // Auto-negotiation engine
  input  wire logic        an_speed_100,
  input  wire logic        an_full_duplex,
  input  wire logic        an_started,
  output logic             an_restart,
  // Datapath controls
  input  wire logic        tx_active,
  output logic             col_out,
  output logic             loopback,
  output logic             speed_100,
  output logic             full_duplex,
  output logic             an_enable,
  output logic             power_down,
  output logic             isolate,
  output logic             phy_soft_rst,
  output logic             rx_dead
);
  import phy_ctrl_pkg::*;

  // A zero hold would cut soft reset to the write cycle; a zero dead time never raises rx_dead
  if (RESET_HOLD < 1)
  begin
    $error("RESET_HOLD must be at least 1");
  end
  if (DEAD_TIME < 1)
  begin
    $error("DEAD_TIME must be at least 1");
  end

  phy_ctrl_if rst_t ();

  logic        loop_r;
  logic        speed_r;
  logic        an_en_r;
  logic        pd_r;
  logic        iso_r;
  logic        restart_r;
  logic        dup_r;
  logic        col_r;
  logic        srst_r;
  logic        busy_d_r;
  logic [31:0] dead_cnt_r;
  logic        wr_hit;
  logic        srst_req;
  logic        eff_speed;
  logic        eff_dup;

  assign wr_hit   = wr_en && (reg_addr == PHY_BASIC_CONTROL);
  assign srst_req = wr_hit && wr_data[BIT_SOFT_RESET];
  assign rst_t.start = srst_req;

  phy_hold_timer #(
    .COUNT (RESET_HOLD)
  ) u_hold (
    .clk     (clk),
    .sys_rst (sys_rst),
    .t       (rst_t.timer)
  );

  // Soft reset flag stays one while the hold timer runs
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      srst_r   <= 1'b0;
      busy_d_r <= 1'b0;
    end
    else
    begin
      busy_d_r <= rst_t.busy;
      srst_r   <= srst_req || rst_t.busy;
    end
  end

  // Control fields; writes ignored while soft reset is in progress
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      loop_r  <= CTRL_RESET_VAL[BIT_LOOPBACK];
      speed_r <= CTRL_RESET_VAL[BIT_SPEED];
      an_en_r <= CTRL_RESET_VAL[BIT_AN_ENABLE];
      pd_r    <= CTRL_RESET_VAL[BIT_POWER_DOWN];
      iso_r   <= CTRL_RESET_VAL[BIT_ISOLATE];
      dup_r   <= CTRL_RESET_VAL[BIT_DUPLEX];
      col_r   <= CTRL_RESET_VAL[BIT_COL_TEST];
    end
    else if (srst_req || rst_t.busy)
    begin
      loop_r  <= CTRL_RESET_VAL[BIT_LOOPBACK];
      speed_r <= CTRL_RESET_VAL[BIT_SPEED];
      an_en_r <= CTRL_RESET_VAL[BIT_AN_ENABLE];
      pd_r    <= CTRL_RESET_VAL[BIT_POWER_DOWN];
      iso_r   <= CTRL_RESET_VAL[BIT_ISOLATE];
      dup_r   <= CTRL_RESET_VAL[BIT_DUPLEX];
      col_r   <= CTRL_RESET_VAL[BIT_COL_TEST];
    end
    else if (wr_hit)
    begin
      loop_r  <= wr_data[BIT_LOOPBACK];
      speed_r <= wr_data[BIT_SPEED];
      an_en_r <= wr_data[BIT_AN_ENABLE];
      pd_r    <= wr_data[BIT_POWER_DOWN];
      iso_r   <= wr_data[BIT_ISOLATE];
      // Duplex only writable by a word that leaves negotiation off
      if (!wr_data[BIT_AN_ENABLE])
        dup_r <= wr_data[BIT_DUPLEX];
      col_r   <= wr_data[BIT_COL_TEST];
    end
  end

  // Restart: set by a write of one with AN on, cleared by engine start, AN off or soft reset.
  // Set wins over the start and AN-off clears; a zero in bit 9 by itself never cancels it.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      restart_r <= 1'b0;
    else if (srst_req || rst_t.busy)
      restart_r <= 1'b0;
    else if (wr_hit && wr_data[BIT_AN_RESTART] && wr_data[BIT_AN_ENABLE])
      restart_r <= 1'b1;
    else if (an_started || !an_en_r)
      restart_r <= 1'b0;
  end

  // Written speed and duplex are kept for when negotiation is turned off
  assign eff_speed = an_en_r ? an_speed_100 : speed_r;
  assign eff_dup   = an_en_r ? an_full_duplex : dup_r;

  // Dead time after loop-back is enabled at 100 Mbps
  // Counted in clk cycles; 32 bits hold the full interval at 25 MHz
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      dead_cnt_r <= '0;
    else if (wr_hit && wr_data[BIT_LOOPBACK] && !loop_r && eff_speed)
      dead_cnt_r <= 32'(DEAD_TIME);
    else if (dead_cnt_r != '0)
      dead_cnt_r <= dead_cnt_r - 32'd1;
  end

  // Register read: answer one cycle after rd_en; power-down does not block it
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_data  <= '0;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= rd_en;
      if (rd_en && reg_addr == PHY_BASIC_CONTROL)
        rd_data <= {srst_r, loop_r, eff_speed, an_en_r, pd_r, iso_r,
                    restart_r, eff_dup, col_r, 7'h00};
      else
        rd_data <= 16'h0000;
    end
  end

  // Registered outputs
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      col_out      <= 1'b0;
      loopback     <= 1'b0;
      speed_100    <= 1'b0;
      full_duplex  <= 1'b0;
      an_enable    <= 1'b0;
      power_down   <= 1'b0;
      isolate      <= 1'b0;
      an_restart   <= 1'b0;
      phy_soft_rst <= 1'b0;
      rx_dead      <= 1'b0;
    end
    else
    begin
      col_out      <= col_r && tx_active;
      loopback     <= loop_r;
      speed_100    <= eff_speed;
      full_duplex  <= eff_dup;
      an_enable    <= an_en_r;
      power_down   <= pd_r;
      isolate      <= iso_r;
      an_restart   <= restart_r;
      phy_soft_rst <= srst_r || busy_d_r;
      rx_dead      <= (dead_cnt_r != '0);
    end
  end
endmodule

// [verification/phy_ctrl_assertions.sv]
// Port checker for the basic control register.
// Assumes binding onto the register block with RESET_HOLD of 8.
`timescale 1ns/1ps
module phy_ctrl_assertions (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register port
  input wire logic [4:0]  reg_addr,
  input wire logic        wr_en,
  input wire logic [15:0] wr_data,
  input wire logic        rd_en,
  input wire logic [15:0] rd_data,
  input wire logic        rd_valid,
  // Negotiation and datapath
  input wire logic        an_speed_100,
  input wire logic        an_started,
  input wire logic        an_restart,
  input wire logic        tx_active,
  input wire logic        col_out,
  input wire logic        speed_100,
  input wire logic        an_enable,
  input wire logic        power_down,
  input wire logic        isolate,
  input wire logic        phy_soft_rst
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence soft_hold;
    phy_soft_rst [*8];
  endsequence
  sequence soft_end;
    phy_soft_rst ##1 !phy_soft_rst;
  endsequence
  a_read_answer: assert property (rd_en |=> rd_valid)
    else $error("read unanswered");
  a_reserved_zero: assert property (rd_valid |-> rd_data[6:0] == 7'h00)
    else $error("reserved bits set");
  a_unmapped_zero: assert property (rd_en && reg_addr != 5'h00 |=> rd_data == 16'h0000)
    else $error("unmapped read not zero");
  a_col_needs_tx: assert property (col_out |-> $past(tx_active))
    else $error("collision without transmit");
  a_speed_follows: assert property (an_enable && $past(an_enable) && $stable(an_speed_100)
    |-> speed_100 == an_speed_100)
    else $error("speed ignores negotiation");
  a_soft_reset: assert property ($rose(phy_soft_rst) |-> soft_hold ##1 soft_end)
    else $error("soft reset length");
  a_write_ctrls: assert property (wr_en && reg_addr == 5'h00 && !phy_soft_rst
    && !$past(wr_en) |-> ##2 power_down == ($past(wr_data[11], 2) && !$past(wr_data[15], 2))
    && isolate == ($past(wr_data[10], 2) && !$past(wr_data[15], 2)))
    else $error("write not applied");
  a_restart_clears: assert property (an_restart && an_started && !wr_en |-> ##2 !an_restart)
    else $error("restart stuck");
endmodule

// [verification/an_engine_model.sv]
// Negotiation engine stand-in facing the control register.
// Assumes one clock; results are levels set by the bench.
`timescale 1ns/1ps
module an_engine_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // Requests and results
  input  wire logic an_restart,
  input  wire logic res_spd,
  input  wire logic res_fdx,
  output logic      an_speed_100,
  output logic      an_full_duplex,
  output logic      an_started
);
  logic [2:0] wait_r;
  assign an_speed_100   = res_spd;
  assign an_full_duplex = res_fdx;
  // Slow start so the pending restart bit can be read back
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      wait_r <= 3'h0;
    else if (!an_restart || an_started)
      wait_r <= 3'h0;
    else
      wait_r <= wait_r + 3'h1;
  end
  assign an_started = (wait_r == 3'h6);
endmodule

// [verification/testbench.sv]
// Self-checking bench for the basic control register.
// Assumes the checker and the negotiation model are compiled first.
`timescale 1ns/1ps
module testbench;
  import phy_ctrl_pkg::*;
  logic        clk = 1'b0, sys_rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, tx_active = 1'b0;
  logic        res_spd = 1'b1, res_fdx = 1'b1;
  logic [4:0]  reg_addr = 5'h00;
  logic [15:0] wr_data = 16'h0000, rd_data;
  logic        rd_valid, an_speed_100, an_full_duplex, an_started, an_restart, col_out;
  logic        loopback, speed_100, full_duplex, an_enable, power_down, isolate;
  logic        phy_soft_rst, rx_dead;
  int          mismatches = 0, checks = 0;
  always #20 clk = ~clk;
  localparam int HOLD_SIM = 8;
  localparam int DEAD_SIM = 20;
  phy_basic_mode_control #(.RESET_HOLD(HOLD_SIM), .DEAD_TIME(DEAD_SIM)) DUT (.*);
  an_engine_model agent (.*);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] d);
    @(posedge clk);
    reg_addr <= 5'h00;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk({15'h0, rd_valid}, 16'h0001);
    chk(rd_data, exp);
  endtask
  // Bounded wait; a hang ends the run as a failure
  task automatic wait_lvl(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (s !== v)
    begin
      mismatches++;
      complete_run();
    end
  endtask
  task automatic t_fixed;
    rdc(5'h00, CTRL_RESET_VAL);
    rdc(5'h01, 16'h0000);
    wr(16'h41ff);
    rdc(5'h00, 16'h4180);
    wr(16'h0980);
    rdc(5'h00, 16'h0980);
    chk({13'h0, isolate, power_down, loopback}, 16'h0002);
    @(posedge clk);
    tx_active <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({15'h0, col_out}, 16'h0001);
    @(posedge clk);
    tx_active <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({15'h0, col_out}, 16'h0000);
  endtask
  // Dead interval measured edge by edge against the configured length
  task automatic t_dead;
    int n;
    n = 0;
    wait_lvl(rx_dead, 1'b0);
    wr(16'h2000);
    wr(16'h6000);
    wait_lvl(rx_dead, 1'b1);
    while (rx_dead === 1'b1 && n < 100)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(16'(n), 16'(DEAD_SIM));
  endtask
  task automatic t_an;
    @(posedge clk);
    res_spd <= 1'b0;
    res_fdx <= 1'b0;
    wr(16'h3100);
    rdc(5'h00, 16'h1000);
    chk({13'h0, an_enable, speed_100, full_duplex}, 16'h0004);
    wr(16'h1200);
    wr(16'h1000);
    rdc(5'h00, 16'h1200);
    wait_lvl(an_started, 1'b1);
    rdc(5'h00, 16'h1000);
  endtask
  task automatic t_soft;
    @(posedge clk);
    res_spd <= 1'b1;
    res_fdx <= 1'b1;
    wr(16'h0800);
    wr(16'h8000);
    rdc(5'h00, 16'hb100);
    wr(16'h4000);
    wait_lvl(phy_soft_rst, 1'b0);
    rdc(5'h00, CTRL_RESET_VAL);
    chk({14'h0, loopback, power_down}, 16'h0000);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_fixed();
    t_dead();
    t_an();
    t_soft();
    complete_run();
  end
endmodule
bind phy_basic_mode_control phy_ctrl_assertions watch (.*);
